/* src/urg_uart.sv */
/*
  urg_uart: serial controller with rate generator, modem lines and a
  strobed byte-wide register port.
  Assumes the oscillator input is the core clock; bus, serial and modem
  inputs are asynchronous to it and pass a two-stage synchroniser, except the echo path.
*/
`timescale 1ns/100ps
module urg_uart
  import urg_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // processor port
  input wire logic select_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // serial and modem lines
  input wire logic serial_in_i,
  output logic serial_out_o,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  // requests and clock out
  output logic irq_o,
  output logic tx_hold_empty_o,
  output logic rx_char_available_o,
  output logic clock_out_o
);

  typedef struct packed {
    logic [15:0] sy1;
    logic [15:0] sy2;
    logic rd_act;
    logic wr_act;
    logic [1:0] adr;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic [7:0] hctrl;
    logic co_sel;
    logic [7:0] thr;
    logic the;
    logic tc;
    logic [7:0] flags;
    logic [1:0] ms_prev;
    logic ms_edge;
    logic tc_edge;
    logic irq;
    logic [2:0] pcnt;
    logic [11:0] acc;
    logic sq;
    urg_ser_t tx_st;
    logic [3:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_brk;
    logic tx_line;
    urg_ser_t rx_st;
    logic [3:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic [7:0] rx_hold_reg;
    logic dr;
  } urg_st_t;

  typedef struct packed {
    logic [6:0] rate;
    logic [7:0] fmt;
  } urg_cfg_t;

  localparam urg_st_t ST_RST = '{
    sy1: SY_RST, sy2: SY_RST, hctrl: HC_RST, flags: LS_RST,
    the: 1'b1, tc: 1'b1, tc_edge: 1'b1, ms_prev: 2'h3, tx_line: 1'b1,
    tx_st: URG_IDLE, rx_st: URG_IDLE, default: '0};

  urg_st_t st_r;
  urg_st_t st_nxt;
  urg_cfg_t cfg_r;
  urg_cfg_t cfg_nxt;
  logic rx_push;
  logic rx_in_ready;
  logic [RXQ_W-1:0] rx_push_data;
  logic rx_out_valid;
  logic rx_pop;
  logic [RXQ_W-1:0] rx_out_data;

  // ****************************************
  // received character buffer
  // ****************************************
  urg_fifo #(
    .W(RXQ_W),
    .D(RXQ_D)
  ) u_rxq (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_push),
    .in_ready_o(rx_in_ready),
    .in_data_i(rx_push_data),
    .out_valid_o(rx_out_valid),
    .out_ready_i(rx_pop),
    .out_data_o(rx_out_data)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic act_rd;
    logic act_wr;
    logic rd_end;
    logic wr_end;
    logic [7:0] fl_set;
    logic [7:0] fl_clr;
    logic [2:0] pdiv;
    logic [11:0] n3;
    logic [11:0] sum;
    logic pre_tick;
    logic pre_sq;
    logic tick;
    logic cts_ok;
    logic rx_x;
    logic [3:0] nb;
    logic [7:0] rxd;
    logic [7:0] txd;
    logic [1:0] ms_now;
    urg_mode_t mode;
    st_nxt = st_r;
    cfg_nxt = cfg_r;
    fl_set = 8'h00;
    fl_clr = 8'h00;
    rx_push = 1'b0;
    rx_push_data = '0;
    rx_pop = 1'b0;
    rxd = 8'h00;
    txd = 8'h00;
    mode = urg_mode_t'(st_r.hctrl[HC_MODE_LO +: 2]);
    nb = 4'h5 + {2'h0, cfg_r.fmt[FMT_LEN_LO +: 2]};
    st_nxt.sy1 = {select_n_i, rd_n_i, wr_n_i, addr_i, data_i,
                  serial_in_i, cts_n_i, dsr_n_i};
    st_nxt.sy2 = st_r.sy1;
    act_rd = !st_r.sy2[SY_SEL] && !st_r.sy2[SY_RD];
    act_wr = !st_r.sy2[SY_SEL] && !st_r.sy2[SY_WR];
    st_nxt.rd_act = act_rd;
    st_nxt.wr_act = act_wr;
    // side effects land at the trailing edge, as strobes end
    rd_end = st_r.rd_act && !act_rd;
    wr_end = st_r.wr_act && !act_wr;
    if (act_wr || act_rd) begin
      st_nxt.adr = st_r.sy2[SY_ADR_LO +: 2];
      st_nxt.wdat = st_r.sy2[SY_DAT_LO +: 8];
    end

    // ****************************************
    // register read mux
    // ****************************************
    if (act_rd) begin
      case (st_r.sy2[SY_ADR_LO +: 2])
        ADR_HOLD: st_nxt.rdat = st_r.rx_hold_reg;
        ADR_FMT_STAT: st_nxt.rdat = st_r.flags;
        ADR_HCTRL: st_nxt.rdat = st_r.hctrl;
        default: st_nxt.rdat = {6'h00, ~st_r.sy2[SY_DSR], ~st_r.sy2[SY_CTS]};
      endcase
    end

    // ****************************************
    // register writes and read side effects
    // ****************************************
    if (wr_end) begin
      case (st_r.adr)
        ADR_HOLD: begin
          st_nxt.thr = st_r.wdat;
          st_nxt.the = 1'b0;
          st_nxt.tc = 1'b0;
        end
        ADR_FMT_STAT: cfg_nxt.fmt = {2'h0, st_r.wdat[5:0]};
        ADR_HCTRL: st_nxt.hctrl = {1'b0, st_r.wdat[6:0]};
        default: begin
          st_nxt.co_sel = st_r.wdat[RATE_CO_SEL];
          cfg_nxt.rate = st_r.wdat[6:0];
        end
      endcase
    end
    if (rd_end && st_r.adr == ADR_FMT_STAT) begin
      fl_clr = 8'hff;
      st_nxt.tc_edge = 1'b0;
      st_nxt.ms_edge = 1'b0;
    end
    if (rd_end && st_r.adr == ADR_RATE_HSTAT) begin
      st_nxt.ms_edge = 1'b0;
    end

    // ****************************************
    // rate generator
    // ****************************************
    // prescaler chained to divisor
    pdiv = urg_pre_div(cfg_r.rate[RATE_PRE_LO +: 2]);
    pre_tick = (st_r.pcnt >= pdiv - 3'h1);
    st_nxt.pcnt = pre_tick ? 3'h0 : st_r.pcnt + 3'h1;
    pre_sq = (st_r.pcnt < {1'b0, pdiv[2:1]});
    n3 = urg_div3(cfg_r.rate[RATE_DIV_LO +: 5]);
    sum = st_r.acc + 12'h003;
    tick = 1'b0;
    if (n3 == 12'h000) begin
      tick = pre_tick;
      st_nxt.acc = 12'h000;
      // odd prescale keeps its odd duty
      st_nxt.sq = pre_sq;
    end else begin
      if (pre_tick) begin
        if (sum >= n3) begin
          st_nxt.acc = sum - n3;
          tick = 1'b1;
        end else begin
          st_nxt.acc = sum;
        end
      end
      st_nxt.sq = (st_r.acc < {1'b0, n3[11:1]});
    end

    // ****************************************
    // transmitter
    // ****************************************
    // clear-to-send checked only before start
    cts_ok = !st_r.sy2[SY_CTS] || mode == URG_LOOP;
    txd = st_r.thr & (8'hff >> (4'h8 - nb));
    case (st_r.tx_st)
      URG_IDLE: begin
        st_nxt.tx_line = 1'b1;
        if (!st_r.the && cts_ok && mode != URG_ECHO) begin
          st_nxt.tx_sh = txd;
          st_nxt.tx_par = (^txd) ^ cfg_r.fmt[FMT_PAR_ODD];
          st_nxt.tx_brk = (mode == URG_BREAK);
          st_nxt.the = 1'b1;
          st_nxt.tx_cnt = 4'h0;
          st_nxt.tx_bit = 4'h0;
          st_nxt.tx_st = URG_START;
          // start bit drops now, else it runs one clock short
          st_nxt.tx_line = 1'b0;
        end
      end
      URG_START: begin
        st_nxt.tx_line = 1'b0;
        if (tick) begin
          st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
          if (st_r.tx_cnt == SUB_LAST) begin
            st_nxt.tx_st = URG_DATA;
            st_nxt.tx_line = st_r.tx_sh[0] && !st_r.tx_brk;
          end
        end
      end
      URG_DATA: begin
        if (tick) begin
          st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
          if (st_r.tx_cnt == SUB_LAST) begin
            st_nxt.tx_sh = st_r.tx_sh >> 1;
            st_nxt.tx_bit = st_r.tx_bit + 4'h1;
            st_nxt.tx_line = st_r.tx_sh[1] && !st_r.tx_brk;
            if (st_r.tx_bit == nb - 4'h1) begin
              st_nxt.tx_bit = 4'h0;
              st_nxt.tx_st = cfg_r.fmt[FMT_PAR_EN] ? URG_PAR : URG_STOP;
              st_nxt.tx_line = cfg_r.fmt[FMT_PAR_EN] ? (st_r.tx_par && !st_r.tx_brk)
                                                     : !st_r.tx_brk;
            end
          end
        end
      end
      URG_PAR: begin
        if (tick) begin
          st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
          if (st_r.tx_cnt == SUB_LAST) begin
            st_nxt.tx_st = URG_STOP;
            st_nxt.tx_line = !st_r.tx_brk;
          end
        end
      end
      URG_STOP: begin
        if (tick) begin
          st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
          if (st_r.tx_cnt == SUB_LAST) begin
            st_nxt.tx_bit = st_r.tx_bit + 4'h1;
            if (st_r.tx_bit[0] || !cfg_r.fmt[FMT_STOP2]) begin
              st_nxt.tx_st = URG_IDLE;
              st_nxt.tx_line = 1'b1;
              st_nxt.tc = st_r.the;
            end
          end
        end
      end
      default: st_nxt.tx_st = URG_IDLE;
    endcase

    // ****************************************
    // receiver
    // ****************************************
    // loop feeds transmit line, pin ignored
    rx_x = (mode == URG_LOOP) ? st_r.tx_line : st_r.sy2[SY_SIN];
    if (!st_r.hctrl[HC_RX_EN]) begin
      rx_x = 1'b1;
    end
    if (tick) begin
      st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
      case (st_r.rx_st)
        URG_IDLE: begin
          st_nxt.rx_cnt = 4'h0;
          if (!rx_x) begin
            st_nxt.rx_st = URG_START;
          end
        end
        URG_START: begin
          if (st_r.rx_cnt == MID_START) begin
            st_nxt.rx_cnt = 4'h0;
            st_nxt.rx_bit = 4'h0;
            st_nxt.rx_st = rx_x ? URG_IDLE : URG_DATA;
          end
        end
        URG_DATA: begin
          if (st_r.rx_cnt == SUB_LAST) begin
            st_nxt.rx_sh = {rx_x, st_r.rx_sh[7:1]};
            st_nxt.rx_bit = st_r.rx_bit + 4'h1;
            if (st_r.rx_bit == nb - 4'h1) begin
              st_nxt.rx_par = 1'b0;
              st_nxt.rx_st = cfg_r.fmt[FMT_PAR_EN] ? URG_PAR : URG_STOP;
            end
          end
        end
        URG_PAR: begin
          if (st_r.rx_cnt == SUB_LAST) begin
            st_nxt.rx_par = rx_x;
            st_nxt.rx_st = URG_STOP;
          end
        end
        URG_STOP: begin
          if (st_r.rx_cnt == SUB_LAST) begin
            rxd = st_r.rx_sh >> (4'h8 - nb);
            rx_push = 1'b1;
            rx_push_data = {rxd == 8'h00 && !st_r.rx_par && !rx_x, !rx_x,
                            cfg_r.fmt[FMT_PAR_EN]
                              && (((^rxd) ^ st_r.rx_par) != cfg_r.fmt[FMT_PAR_ODD]),
                            rxd};
            st_nxt.rx_st = URG_IDLE;
          end
        end
        default: st_nxt.rx_st = URG_IDLE;
      endcase
    end
    // a full buffer cannot stall the wire, so the character is lost
    fl_set[LS_OVR_ERR] = rx_push && !rx_in_ready;

    // ****************************************
    // holding register and flags
    // ****************************************
    if (rd_end && st_r.adr == ADR_HOLD) begin
      st_nxt.dr = 1'b0;
    end
    if (!st_r.dr && rx_out_valid) begin
      rx_pop = 1'b1;
      st_nxt.rx_hold_reg = rx_out_data[7:0];
      st_nxt.dr = 1'b1;
      fl_set[LS_RX_AVAIL] = 1'b1;
      fl_set[LS_PAR_ERR] = rx_out_data[8];
      fl_set[LS_FRM_ERR] = rx_out_data[9];
      fl_set[LS_BREAK] = rx_out_data[10];
    end
    ms_now = {st_r.sy2[SY_DSR], st_r.sy2[SY_CTS]};
    st_nxt.ms_prev = ms_now;
    fl_set[LS_MODEM] = (ms_now != st_r.ms_prev);
    fl_set[LS_TX_DONE] = st_nxt.tc && !st_r.tc;
    fl_set[LS_TX_EMPTY] = st_nxt.the && !st_r.the;
    // set wins over a clearing read
    st_nxt.flags = (st_r.flags & ~fl_clr) | fl_set;
    if (fl_set[LS_MODEM]) begin
      st_nxt.ms_edge = 1'b1;
    end
    if (fl_set[LS_TX_DONE]) begin
      st_nxt.tc_edge = 1'b1;
    end
    // master enable gates all, modem enable its edge
    st_nxt.irq = st_r.hctrl[HC_IRQ_EN]
                 && (st_nxt.tc_edge || (st_r.hctrl[HC_HS_IRQ_EN] && st_nxt.ms_edge));
  end

  // ****************************************
  // registers
  // ****************************************
  // reset loads ST_RST into state, keeps format and rate
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // format and rate survive reset, so they carry none
  always_ff @(posedge core_clk_i) begin
    cfg_r <= cfg_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign data_o = st_r.rdat;
  assign data_oe_o = st_r.rd_act;
  assign dtr_n_o = !st_r.hctrl[HC_DTR];
  assign rts_n_o = !st_r.hctrl[HC_RTS];
  assign irq_o = st_r.irq;
  assign tx_hold_empty_o = st_r.the;
  assign rx_char_available_o = st_r.dr;

  // echo passes the pin unsynchronised, parity intact
  always_comb begin
    case (urg_mode_t'(st_r.hctrl[HC_MODE_LO +: 2]))
      URG_ECHO: serial_out_o = serial_in_i;
      URG_LOOP: serial_out_o = 1'b1;
      default: serial_out_o = st_r.tx_line;
    endcase
  end

  always_comb begin
    clock_out_o = core_clk_i;
    if (st_r.co_sel && (urg_div3(cfg_r.rate[RATE_DIV_LO +: 5]) != 12'h000
        || cfg_r.rate[RATE_PRE_LO +: 2] != 2'h0)) begin
      clock_out_o = st_r.sq;
    end
  end

endmodule

/* src/urg_pkg.sv */
/*
  urg_pkg: constants, field positions, reset values and mode and state
  types shared by the serial controller, its checker and its testbench.
  Assumes a single 25 MHz core clock that also stands in for the
  oscillator input.
*/
package urg_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int RST_MIN_OSC_PERIODS = 2;
  localparam int RST_MIN_CYC = RST_MIN_OSC_PERIODS;
  localparam logic [3:0] SUB_LAST = 4'h0f;
  localparam logic [3:0] MID_START = 4'h07;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [1:0] ADR_HOLD = 2'h0;
  localparam logic [1:0] ADR_FMT_STAT = 2'h1;
  localparam logic [1:0] ADR_HCTRL = 2'h2;
  localparam logic [1:0] ADR_RATE_HSTAT = 2'h3;

  // ****************************************
  // line_format_reg fields
  // ****************************************
  localparam int FMT_LEN_LO = 0;
  localparam int FMT_STOP2 = 2;
  localparam int FMT_PAR_EN = 3;
  localparam int FMT_PAR_ODD = 4;

  // ****************************************
  // rate_select_reg fields
  // ****************************************
  localparam int RATE_DIV_LO = 0;
  localparam int RATE_PRE_LO = 5;
  localparam int RATE_CO_SEL = 7;

  // ****************************************
  // handshake_ctrl_reg fields
  // ****************************************
  localparam int HC_DTR = 0;
  localparam int HC_RTS = 1;
  localparam int HC_IRQ_EN = 2;
  localparam int HC_HS_IRQ_EN = 3;
  localparam int HC_MODE_LO = 4;
  localparam int HC_RX_EN = 6;
  localparam logic [7:0] HC_RST = 8'h00;

  // ****************************************
  // line_status_reg fields
  // ****************************************
  localparam int LS_PAR_ERR = 0;
  localparam int LS_FRM_ERR = 1;
  localparam int LS_OVR_ERR = 2;
  localparam int LS_BREAK = 3;
  localparam int LS_MODEM = 4;
  localparam int LS_TX_DONE = 5;
  localparam int LS_TX_EMPTY = 6;
  localparam int LS_RX_AVAIL = 7;
  localparam logic [7:0] LS_RST = 8'h60;

  // ****************************************
  // synchroniser vector layout
  // ****************************************
  localparam int SY_DSR = 0;
  localparam int SY_CTS = 1;
  localparam int SY_SIN = 2;
  localparam int SY_DAT_LO = 3;
  localparam int SY_ADR_LO = 11;
  localparam int SY_WR = 13;
  localparam int SY_RD = 14;
  localparam int SY_SEL = 15;
  localparam logic [15:0] SY_RST = 16'he007;

  // ****************************************
  // receive buffer
  // ****************************************
  localparam int RXQ_W = 11;
  localparam int RXQ_D = 32;

  // ****************************************
  // modes and states
  // ****************************************
  typedef enum logic [1:0] {
    URG_NORMAL,
    URG_BREAK,
    URG_ECHO,
    URG_LOOP
  } urg_mode_t;

  typedef enum logic [2:0] {
    URG_IDLE,
    URG_START,
    URG_DATA,
    URG_PAR,
    URG_STOP
  } urg_ser_t;

  // prescaler ratio for a 2-bit select: 1, 3, 4, 5
  function automatic logic [2:0] urg_pre_div(input logic [1:0] sel);
    case (sel)
      2'h0: urg_pre_div = 3'h1;
      2'h1: urg_pre_div = 3'h3;
      2'h2: urg_pre_div = 3'h4;
      default: urg_pre_div = 3'h5;
    endcase
  endfunction

  // divisor in thirds; zero means external, no division
  function automatic logic [11:0] urg_div3(input logic [4:0] sel);
    case (sel)
      5'h01: urg_div3 = 12'h006;
      5'h02: urg_div3 = 12'h00c;
      5'h03: urg_div3 = 12'h010;
      5'h04: urg_div3 = 12'h018;
      5'h05: urg_div3 = 12'h020;
      5'h06: urg_div3 = 12'h030;
      5'h07: urg_div3 = 12'h03a;
      5'h08: urg_div3 = 12'h042;
      5'h09: urg_div3 = 12'h060;
      5'h0a: urg_div3 = 12'h0c0;
      5'h0b: urg_div3 = 12'h180;
      5'h0c: urg_div3 = 12'h240;
      5'h0d: urg_div3 = 12'h300;
      5'h0e: urg_div3 = 12'h360;
      5'h0f: urg_div3 = 12'h420;
      5'h10: urg_div3 = 12'h600;
      5'h11: urg_div3 = 12'h900;
      default: urg_div3 = 12'h000;
    endcase
  endfunction

endpackage

/* src/urg_fifo.sv */
/*
  urg_fifo: valid/ready buffer with width and depth parameters.
  Assumes one clock and an asynchronous active-high reset; depth is a
  power of two.
*/
`timescale 1ns/100ps
module urg_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } urg_fifo_st_t;

  urg_fifo_st_t st_r;
  urg_fifo_st_t st_nxt;
  logic [W-1:0] mem_r [D];
  logic full;
  logic empty;
  logic push;
  logic pop;

  // ****************************************
  // flags
  // ****************************************
  assign empty = (st_r.wp == st_r.rp);
  assign full = (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]) && (st_r.wp[AW] != st_r.rp[AW]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  assign out_data_o = mem_r[st_r.rp[AW-1:0]];

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  // storage carries no reset; only pointers need a defined value
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_r[st_r.wp[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

/* tb/urg_uart_checker.sv */
/* urg_uart_checker: port assertions for the serial controller.
   assumes a bind onto urg_uart and one clock domain. */
`timescale 1ns/100ps
module urg_uart_checker
  import urg_pkg::*;
(
  // watched ports
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic select_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [1:0] addr_i,
  input wire logic data_oe_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic irq_o,
  input wire logic tx_hold_empty_o,
  input wire logic rx_char_available_o
);
  // ****************
  // bus sequences
  // ****************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence rd_on;
    !select_n_i && !rd_n_i;
  endsequence
  sequence wr_on;
    !select_n_i && !wr_n_i && rd_n_i;
  endsequence
  // side effects land 3 edges after release; one cycle of slack either way
  idle_rst_a: assert property (
    $fell(rst_i) |-> tx_hold_empty_o && !rx_char_available_o && rts_n_o && dtr_n_o && !irq_o)
    else $error("bad idle levels after reset");
  oe_cause_a: assert property (
    $rose(data_oe_o) |-> !$past(select_n_i, 2) && !$past(rd_n_i, 2))
    else $error("bus driven without select and read");
  sel_off_a: assert property (
    select_n_i[*4] |=> !data_oe_o)
    else $error("bus driven while deselected");
  rd_drive_a: assert property (
    rd_on[*4] |=> data_oe_o)
    else $error("read not answered");
  wr_quiet_a: assert property (
    wr_on[*5] |=> !data_oe_o)
    else $error("bus driven during write");
  hold_fill_a: assert property (
    $fell(tx_hold_empty_o) |-> (!$past(wr_n_i, 5) && $past(addr_i, 5) == ADR_HOLD)
      || (!$past(wr_n_i, 6) && $past(addr_i, 6) == ADR_HOLD))
    else $error("hold empty dropped without write");
  rx_clear_a: assert property (
    $fell(rx_char_available_o) |-> (!$past(rd_n_i, 5) && $past(addr_i, 5) == ADR_HOLD)
      || (!$past(rd_n_i, 6) && $past(addr_i, 6) == ADR_HOLD))
    else $error("data ready dropped without read");
  rts_write_a: assert property (
    $changed(rts_n_o) |-> (!$past(wr_n_i, 5) && $past(addr_i, 5) == ADR_HCTRL)
      || (!$past(wr_n_i, 6) && $past(addr_i, 6) == ADR_HCTRL))
    else $error("request line moved without write");
endmodule

/* tb/urg_modem.sv */
/* urg_modem: far-end serial line model.
   assumes the rate is sixteen core clocks per bit. */
`timescale 1ns/100ps
module urg_modem (
  // line to the controller
  input wire logic core_clk_i,
  output logic line_o
);
  // mark while idle, so an open line never looks like a start
  initial line_o = 1'h1;
  // one 8N1 frame, lsb first
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      line_o = f[i];
      repeat (16) @(negedge core_clk_i);
    end
  endtask
endmodule

/* tb/test_urg_uart.sv */
/* test_urg_uart: register table, then serial scenarios.
   assumes package, design, modem and checker compiled first. */
`timescale 1ns/100ps
module test_urg_uart;
  import urg_pkg::*;
  logic clk, rst, sel_n, rd_n, wr_n, cts_n, dsr_n, sin, sout, oe;
  logic rts_n, dtr_n, irq, the, rxa, co;
  logic [1:0] adr;
  logic [7:0] wd, rdat, v, st;
  logic [9:0] f;
  logic [11:0] rows [9];
  int num_errors = 0;
  int n_tests = 0;
  urg_uart i_urg_uart(.core_clk_i(clk), .rst_i(rst), .select_n_i(sel_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .addr_i(adr), .data_i(wd), .data_o(rdat), .data_oe_o(oe),
    .serial_in_i(sin), .serial_out_o(sout), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .irq_o(irq), .tx_hold_empty_o(the),
    .rx_char_available_o(rxa), .clock_out_o(co));
  urg_modem i_urg_modem(.core_clk_i(clk), .line_o(sin));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // strobes held five clocks, then five idle, beyond the sync latency
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    sel_n = 1'h0;
    adr = a;
    wd = d;
    wr_n = !w;
    rd_n = w;
    repeat (5) @(negedge clk);
    v = rdat;
    {sel_n, rd_n, wr_n} = 3'h7;
    repeat (5) @(negedge clk);
  endtask
  task automatic wait_rx;
    for (int i = 0; i < 400 && rxa !== 1'h1; i++) @(negedge clk);
  endtask
  task automatic grab(input logic [7:0] d);
    fork
      bus(1'h1, ADR_HOLD, d);
      begin
        @(negedge sout);
        repeat (8) @(negedge clk);
        for (int i = 0; i < 10; i++) begin
          f[i] = sout;
          repeat (16) @(negedge clk);
        end
      end
    join
  endtask
  // ****************
  // stimulus
  // ****************
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    summarize;
  end
  initial begin
    {rst, sel_n, rd_n, wr_n, cts_n, dsr_n} = 6'h3f;
    adr = 2'h0;
    wd = 8'h00;
    // w, cts_n, addr, data or expected read
    rows = '{12'h560, 12'h600, 12'hd03, 12'hf00, 12'he43, 12'h643, 12'h301, 12'h110, 12'h100};
    repeat (2) @(negedge clk);
    rst = 1'h0;
    chk({5'h0, the, rxa, rts_n, dtr_n, irq}, 10'h016);
    foreach (rows[i]) begin
      cts_n = rows[i][10];
      bus(rows[i][11], rows[i][9:8], rows[i][7:0]);
      if (!rows[i][11]) chk({2'h0, v}, {2'h0, rows[i][7:0]});
    end
    chk({7'h0, rts_n, dtr_n, irq}, 10'h000);
    i_urg_modem.send(8'ha5);
    wait_rx;
    bus(1'h0, ADR_HOLD, 8'h00);
    chk({1'h0, rxa, v}, 10'h0a5);
    grab(8'h3c);
    chk(f, {1'h1, 8'h3c, 1'h0});
    bus(1'h1, ADR_HCTRL, 8'h53);
    grab(8'hff);
    chk(f, 10'h000);
    bus(1'h1, ADR_HCTRL, 8'h73);
    fork
      i_urg_modem.send(8'h0f);
    join_none
    bus(1'h1, ADR_HOLD, 8'h5a);
    for (int i = 0; i < 300 && rxa !== 1'h1; i++) begin
      @(negedge clk);
      chk({9'h0, sout}, 10'h001);
    end
    bus(1'h0, ADR_HOLD, 8'h00);
    chk({2'h0, v}, 10'h05a);
    bus(1'h1, ADR_HCTRL, 8'h63);
    fork
      i_urg_modem.send(8'h96);
    join_none
    repeat (170) begin
      @(posedge clk) #1;
      chk({9'h0, sout}, {9'h0, sin});
    end
    bus(1'h0, ADR_HOLD, 8'h00);
    bus(1'h1, ADR_HCTRL, 8'h03);
    i_urg_modem.send(8'h11);
    repeat (40) @(negedge clk);
    chk({9'h0, rxa}, 10'h000);
    // buffer filled past capacity, then drained in order
    bus(1'h1, ADR_HCTRL, 8'h43);
    bus(1'h0, ADR_FMT_STAT, 8'h00);
    for (int i = 0; i < 34; i++) i_urg_modem.send(8'(i));
    bus(1'h0, ADR_FMT_STAT, 8'h00);
    st = v;
    chk({2'h0, st & 8'h04}, 10'h004);
    for (int i = 0; i < 33; i++) begin
      bus(1'h0, ADR_HOLD, 8'h00);
      chk({2'h0, v}, 10'(i));
    end
    chk({9'h0, rxa}, 10'h000);
    // rate clock on clock-out toggles every clock at divisor 2
    bus(1'h1, ADR_RATE_HSTAT, 8'h81);
    st[0] = co;
    @(negedge clk);
    chk({8'h0, st[0], co}, {8'h0, st[0], !st[0]});
    // mid-run reset, two clocks, modem lines idle
    {rst, cts_n} = 2'h3;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    chk({5'h0, the, rxa, rts_n, dtr_n, irq}, 10'h016);
    repeat (2) begin
      @(posedge clk) #1;
      chk({9'h0, co}, 10'h001);
    end
    @(negedge clk);
    bus(1'h1, ADR_RATE_HSTAT, 8'h00);
    bus(1'h1, ADR_HCTRL, 8'h44);
    chk({9'h0, irq}, 10'h001);
    bus(1'h0, ADR_FMT_STAT, 8'h00);
    chk({2'h0, v}, 10'h060);
    chk({9'h0, irq}, 10'h000);
    i_urg_modem.send(8'h81);
    wait_rx;
    bus(1'h0, ADR_HOLD, 8'h00);
    chk({2'h0, v}, 10'h081);
    summarize;
  end
endmodule
bind urg_uart urg_uart_checker i_urg_uart_checker(.core_clk_i, .rst_i, .select_n_i, .rd_n_i,
  .wr_n_i, .addr_i, .data_oe_o, .rts_n_o, .dtr_n_o, .irq_o, .tx_hold_empty_o,
  .rx_char_available_o);
